// File: rtl/cmmc_pkg.sv
// Package: constants and helpers for the mailbox message control store
package cmmc_pkg;
  localparam int MB_COUNT = 16;
  localparam int MB_BYTES = 8;
  localparam int ADDR_W = 12;
  localparam logic [11:0] MC_LAST = 12'h1FC;
  localparam logic [11:0] SEL_OFS = 12'h200;
  localparam logic [11:0] DSTAT_OFS = 12'h204;
  localparam logic [11:0] DID_OFS = 12'h208;
  localparam int MB_LSB = 5;
  localparam int BIDX_LSB = 2;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [3:0] DLC_MAX = 4'h8;
  localparam int BYTE_LEN = 0;
  localparam int BYTE_FLAGS = 4;
  localparam int BYTE_ID_TOP = 5;
  localparam int BYTE_ID_LOW = 6;
  localparam int BYTE_ID_MID = 7;
  localparam int RTR_BIT = 4;
  localparam int IDE_BIT = 3;
  localparam int STD_ID_LSB = 18;
  localparam int DS_RTR = 4;
  localparam int DS_IDE = 5;
  localparam int DS_RAW_LSB = 8;
  localparam int DS_SEL_LSB = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [63:0] cmmc_entry_t;
  typedef enum {CMMC_MC, CMMC_SEL, CMMC_DSTAT, CMMC_DID, CMMC_NONE}
    cmmc_region_e;

  function automatic logic [7:0] cmmc_byte(cmmc_entry_t e, logic [2:0] n);
    return e[8*n +: 8];
  endfunction

  function automatic cmmc_region_e cmmc_region(logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'b00};
    if (w <= MC_LAST) return CMMC_MC;
    else if (w == SEL_OFS) return CMMC_SEL;
    else if (w == DSTAT_OFS) return CMMC_DSTAT;
    else if (w == DID_OFS) return CMMC_DID;
    else return CMMC_NONE;
  endfunction

  function automatic logic [3:0] cmmc_mb(logic [ADDR_W-1:0] a);
    return a[MB_LSB +: 4];
  endfunction

  function automatic logic [2:0] cmmc_bidx(logic [ADDR_W-1:0] a);
    return a[BIDX_LSB +: 3];
  endfunction
endpackage

// File: rtl/cmmc_store.sv
// Mailbox control RAM: one byte write port, two registered read ports
`timescale 1ns/10ps
module cmmc_store #(
  parameter int MB_COUNT = cmmc_pkg::MB_COUNT
) (
  input wire logic mclk,
  input wire logic wrEn,
  input wire logic [3:0] wrMb,
  input wire logic [2:0] wrByte,
  input wire logic [7:0] wrData,
  input wire logic [3:0] rdMbA,
  output cmmc_pkg::cmmc_entry_t rdEntryA,
  input wire logic [3:0] rdMbB,
  output cmmc_pkg::cmmc_entry_t rdEntryB
);
  // No reset: contents survive any reset and start undefined
  cmmc_pkg::cmmc_entry_t mem [MB_COUNT];

  always_ff @(posedge mclk)
  begin
    if (wrEn)
    begin
      mem[wrMb][8*wrByte +: 8] <= wrData;
    end
    rdEntryA <= mem[rdMbA];
    rdEntryB <= mem[rdMbB];
  end
endmodule // cmmc_store

// File: rtl/cmmc_decode.sv
// Field decoder: turns one mailbox entry into frame settings
`timescale 1ns/10ps
module cmmc_decode (
  input cmmc_pkg::cmmc_entry_t entry,
  output logic [3:0] rawDlc,
  output logic [3:0] length,
  output logic rtr,
  output logic ide,
  output logic [28:0] id
);
  logic [7:0] flags;
  logic [7:0] topByte;
  logic [7:0] midByte;
  logic [7:0] lowByte;
  logic [28:0] fullId;

  always_comb
  begin
    flags = cmmc_pkg::cmmc_byte(entry, 3'(cmmc_pkg::BYTE_FLAGS));
    topByte = cmmc_pkg::cmmc_byte(entry, 3'(cmmc_pkg::BYTE_ID_TOP));
    midByte = cmmc_pkg::cmmc_byte(entry, 3'(cmmc_pkg::BYTE_ID_MID));
    lowByte = cmmc_pkg::cmmc_byte(entry, 3'(cmmc_pkg::BYTE_ID_LOW));
    rawDlc = entry[3:0];
    // Remote frames reuse the same field as the requested length
    length = (rawDlc > cmmc_pkg::DLC_MAX) ? cmmc_pkg::DLC_MAX
             : rawDlc;
    rtr = flags[cmmc_pkg::RTR_BIT];
    ide = flags[cmmc_pkg::IDE_BIT];
    fullId = {topByte,
              flags[7:5],
              flags[1:0],
              midByte,
              lowByte};
    id = fullId;
    if (!ide)
    begin
      id[cmmc_pkg::STD_ID_LSB-1:0] = '0;
    end
  end
endmodule // cmmc_decode

// File: rtl/cmmc_top.sv
// Mailbox message control store with AXI4-Lite access and engine port
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module cmmc_top (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [cmmc_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [cmmc_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [3:0] engMbSel,
  output logic [3:0] engLength,
  output logic engRtr,
  output logic engIde,
  output logic [28:0] engId
);
  typedef struct packed {
    logic awReady;
    logic awHave;
    logic [cmmc_pkg::ADDR_W-1:0] awAddr;
    logic wReady;
    logic wHave;
    logic [7:0] wByte;
    logic wLane0;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rPend;
    logic [cmmc_pkg::ADDR_W-1:0] rAddr;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [3:0] selMb;
    logic [3:0] engLen;
    logic engRtr;
    logic engIde;
    logic [28:0] engId;
  } cmmc_state_s;

  cmmc_state_s state_reg;
  cmmc_state_s state_next;

  logic ramWe;
  logic [3:0] ramWrMb;
  logic [2:0] ramWrByte;
  logic [3:0] ramRdMbA;
  cmmc_pkg::cmmc_entry_t entryA;
  cmmc_pkg::cmmc_entry_t entryB;
  logic [3:0] decARaw;
  logic [3:0] decALen;
  logic decARtr;
  logic decAIde;
  logic [28:0] decAId;
  logic [3:0] decBLen;
  logic decBRtr;
  logic decBIde;
  logic [28:0] decBId;
  logic doWrite;
  cmmc_pkg::cmmc_region_e wrRegion;
  cmmc_pkg::cmmc_region_e rdRegion;

  cmmc_store #(
    .MB_COUNT(cmmc_pkg::MB_COUNT)
  ) u_store (
    .mclk(mclk),
    .wrEn(ramWe),
    .wrMb(ramWrMb),
    .wrByte(ramWrByte),
    .wrData(state_reg.wByte),
    .rdMbA(ramRdMbA),
    .rdEntryA(entryA),
    .rdMbB(engMbSel),
    .rdEntryB(entryB)
  );

  cmmc_decode u_dec_bus (
    .entry(entryA),
    .rawDlc(decARaw),
    .length(decALen),
    .rtr(decARtr),
    .ide(decAIde),
    .id(decAId)
  );

  cmmc_decode u_dec_eng (
    .entry(entryB),
    .rawDlc(),
    .length(decBLen),
    .rtr(decBRtr),
    .ide(decBIde),
    .id(decBId)
  );

  assign wrRegion = cmmc_pkg::cmmc_region(state_reg.awAddr);
  assign rdRegion = cmmc_pkg::cmmc_region(state_reg.rAddr);
  assign doWrite = state_reg.awHave && state_reg.wHave && !state_reg.bValid;
  assign ramWe = doWrite && (wrRegion == cmmc_pkg::CMMC_MC)
                 && state_reg.wLane0;
  assign ramWrMb = cmmc_pkg::cmmc_mb(state_reg.awAddr);
  assign ramWrByte = cmmc_pkg::cmmc_bidx(state_reg.awAddr);
  // The read port follows a mailbox request address, else the select register; its word is used
  // only in the cycle right after the address is taken
  assign ramRdMbA = (cmmc_pkg::cmmc_region(araddr) == cmmc_pkg::CMMC_MC) ?
                    cmmc_pkg::cmmc_mb(araddr) : state_reg.selMb;

  always_comb
  begin
    state_next = state_reg;
    // Write address and data are taken in either order
    if (awvalid && state_reg.awReady)
    begin
      state_next.awHave = 1'b1;
      state_next.awAddr = awaddr;
    end
    if (wvalid && state_reg.wReady)
    begin
      state_next.wHave = 1'b1;
      state_next.wByte = wdata[7:0];
      state_next.wLane0 = wstrb[0];
    end
    if (state_reg.bValid && bready)
    begin
      state_next.bValid = 1'b0;
    end
    if (doWrite)
    begin
      state_next.awHave = 1'b0;
      state_next.wHave = 1'b0;
      state_next.bValid = 1'b1;
      state_next.bResp = cmmc_pkg::RESP_OKAY;
      case (wrRegion)
        cmmc_pkg::CMMC_MC: state_next.bResp = cmmc_pkg::RESP_OKAY;
        cmmc_pkg::CMMC_SEL:
        begin
          if (state_reg.wLane0)
          begin
            state_next.selMb = state_reg.wByte[3:0];
          end
        end
        default: state_next.bResp = cmmc_pkg::RESP_SLVERR;
      endcase
    end
    // Reads: address taken, storage read, then answer
    if (state_reg.rValid && rready)
    begin
      state_next.rValid = 1'b0;
    end
    if (arvalid && state_reg.arReady)
    begin
      state_next.rPend = 1'b1;
      state_next.rAddr = araddr;
    end
    if (state_reg.rPend)
    begin
      state_next.rPend = 1'b0;
      state_next.rValid = 1'b1;
      state_next.rData = '0;
      state_next.rResp = cmmc_pkg::RESP_OKAY;
      case (rdRegion)
        cmmc_pkg::CMMC_MC:
          state_next.rData[7:0] = cmmc_pkg::cmmc_byte(entryA,
                                  cmmc_pkg::cmmc_bidx(state_reg.rAddr));
        cmmc_pkg::CMMC_SEL: state_next.rData[3:0] = state_reg.selMb;
        cmmc_pkg::CMMC_DSTAT:
        begin
          state_next.rData[3:0] = decALen;
          state_next.rData[cmmc_pkg::DS_RTR] = decARtr;
          state_next.rData[cmmc_pkg::DS_IDE] = decAIde;
          state_next.rData[cmmc_pkg::DS_RAW_LSB +: 4] = decARaw;
          state_next.rData[cmmc_pkg::DS_SEL_LSB +: 4] = state_reg.selMb;
        end
        cmmc_pkg::CMMC_DID: state_next.rData[28:0] = decAId;
        default: state_next.rResp = cmmc_pkg::RESP_SLVERR;
      endcase
    end
    // Ready flags are registered so every bus output comes from a flop
    state_next.awReady = !state_next.awHave && !state_next.bValid;
    state_next.wReady = !state_next.wHave && !state_next.bValid;
    state_next.arReady = !state_next.rPend && !state_next.rValid;
    // Engine view: two cycles from mailbox select to settled fields
    state_next.engLen = decBLen;
    state_next.engRtr = decBRtr;
    state_next.engIde = decBIde;
    state_next.engId = decBId;
  end

  // Only control state is reset; mailbox storage keeps its content
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= '0;
      state_reg.selMb <= cmmc_pkg::SEL_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign awready = state_reg.awReady;
  assign wready = state_reg.wReady;
  assign bvalid = state_reg.bValid;
  assign bresp = state_reg.bResp;
  assign arready = state_reg.arReady;
  assign rvalid = state_reg.rValid;
  assign rdata = state_reg.rData;
  assign rresp = state_reg.rResp;
  assign engLength = state_reg.engLen;
  assign engRtr = state_reg.engRtr;
  assign engIde = state_reg.engIde;
  assign engId = state_reg.engId;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence s_aw_w_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_ar_take;
    arvalid && arready;
  endsequence
  sequence s_rd_answer;
    !rvalid ##1 rvalid;
  endsequence

  property p_write_answer;
    s_aw_w_take |-> ##2 (bvalid && !awready && !wready);
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write not answered two cycles after taking it");

  property p_read_answer;
    s_ar_take |-> ##1 s_rd_answer;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered two cycles after taking it");

  // Unwritten mailboxes decode to unknowns on both sides, hence case
  // equality; the first edge after reset still shows the reset values
  property p_len_sat;
    $past(resetn) |-> (engLength === (($past(entryB[3:0])
      > cmmc_pkg::DLC_MAX) ? cmmc_pkg::DLC_MAX : $past(entryB[3:0])));
  endproperty
  a_len_sat: assert property (p_len_sat)
    else $error("length code not saturated at eight");

  property p_remote_len;
    engRtr |-> (engLength <= cmmc_pkg::DLC_MAX);
  endproperty
  a_remote_len: assert property (p_remote_len)
    else $error("remote frame length out of range");

  property p_rtr_ide;
    $past(resetn) |-> (engRtr === $past(entryB[36]))
      && (engIde === $past(entryB[35]));
  endproperty
  a_rtr_ide: assert property (p_rtr_ide)
    else $error("frame type or format flag wrong");

  property p_id_mid;
    $past(resetn) && engIde |-> (engId[20:16]
      === {$past(entryB[39:37]), $past(entryB[33:32])});
  endproperty
  a_id_mid: assert property (p_id_mid)
    else $error("identifier bits 20 to 16 wrong");

  property p_id_top;
    $past(resetn) |-> (engId[28:21] === $past(entryB[47:40]));
  endproperty
  a_id_top: assert property (p_id_top)
    else $error("identifier bits 28 to 21 wrong");

  property p_id_low;
    $past(resetn) && engIde |-> (engId[15:0]
      === {$past(entryB[63:56]), $past(entryB[55:48])});
  endproperty
  a_id_low: assert property (p_id_low)
    else $error("identifier bits 15 to 0 wrong");

  property p_std_mask;
    !engIde |-> (engId[17:0] == 18'h0_0000);
  endproperty
  a_std_mask: assert property (p_std_mask)
    else $error("standard identifier low bits not ignored");

  property p_reset_sel;
    $rose(resetn) |-> (state_reg.selMb == cmmc_pkg::SEL_RESET);
  endproperty
  a_reset_sel: assert property (@(posedge mclk) p_reset_sel)
    else $error("select register not initialised by reset");
endmodule // cmmc_top

// File: bench/testbench.sv
// Self-checking bench for the mailbox message control store
`timescale 1ns/10ps
module testbench;
  logic mclk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, engRtr, engIde;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, engMbSel, engLength;
  logic [1:0] bresp, rresp;
  logic [28:0] engId;
  int errorCnt, nTests;
  logic [7:0] tbl [8] = '{8'hA5, 8'h5A, 8'hC3, 8'h3C,
    8'hAE, 8'h96, 8'h21, 8'h84};

  cmmc_top uut (.mclk(mclk), .resetn(resetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .engMbSel(engMbSel), .engLength(engLength), .engRtr(engRtr),
    .engIde(engIde), .engId(engId));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string msg);
    nTests++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Mailbox m byte n (1..8) as a byte address
  function automatic logic [11:0] mcAddr(input int m, input int n);
    return 12'((m * 8 + n - 1) * 4);
  endfunction

  // Ready for responses is held high, so each wait ends at the answer edge
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    r = bresp;
    if (n >= 50)
    begin
      errorCnt++;
      final_report();
    end
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    if (n >= 50)
    begin
      errorCnt++;
      final_report();
    end
  endtask

  // Held select; the third edge still shows what the second edge loaded
  task automatic eng_peek(input logic [3:0] m);
    engMbSel <= m;
    repeat (3) @(posedge mclk);
  endtask

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask

  // Identifier of mailbox 3 as laid out by test_layout
  localparam logic [31:0] EXT_ID3 = {3'h0, 8'h96, 3'b101, 2'b10, 8'h84,
    8'h21};

  // Every control bit gets a defined value before any use
  task automatic test_init();
    logic [1:0] r;
    for (int m = 0; m < 16; m++)
    begin
      for (int n = 1; n <= 8; n++)
      begin
        axi_write(mcAddr(m, n), 8'h00, r);
        chk({30'h0, r}, 32'h0000_0000, "init resp");
      end
    end
    $display("test_init done");
  endtask

  task automatic test_layout();
    logic [31:0] d;
    logic [1:0] r;
    for (int n = 1; n <= 8; n++)
    begin
      axi_write(mcAddr(3, n), tbl[n-1], r);
      axi_write(mcAddr(12, n), ~tbl[n-1], r);
    end
    for (int n = 1; n <= 8; n++)
    begin
      axi_read(mcAddr(3, n), d, r);
      chk(d, {24'h00_0000, tbl[n-1]}, "mailbox 3 byte");
      chk({30'h0, r}, 32'h0000_0000, "read resp");
      axi_read(mcAddr(12, n), d, r);
      chk(d, {24'h00_0000, ~tbl[n-1]}, "mailbox 12 byte");
    end
    eng_peek(4'h3);
    chk({28'h0, engLength}, 32'h0000_0005, "length");
    chk({31'h0, engRtr}, 32'h0000_0000, "data frame");
    chk({31'h0, engIde}, 32'h0000_0001, "extended");
    chk({3'h0, engId}, EXT_ID3, "ext id");
    $display("test_layout done");
  endtask

  task automatic test_length();
    logic [31:0] d;
    logic [31:0] sat;
    logic [1:0] r;
    axi_write(mcAddr(7, 5), 8'h18, r);
    for (int c = 0; c < 16; c++)
    begin
      sat = (c > 8) ? 32'h0000_0008 : 32'(c);
      axi_write(mcAddr(7, 1), 8'(c), r);
      axi_read(mcAddr(7, 1), d, r);
      chk(d, 32'(c), "raw code");
      eng_peek(4'h7);
      chk({28'h0, engLength}, sat, "sat len");
      chk({31'h0, engRtr}, 32'h0000_0001, "remote");
    end
    // Bus view of mailbox 7: length 8, remote, extended, raw 15, select 7
    axi_write(12'h200, 8'h07, r);
    axi_read(12'h204, d, r);
    chk(d, 32'h0000_7F38, "status view");
    $display("test_length done");
  endtask

  task automatic test_standard();
    logic [31:0] d;
    logic [1:0] r;
    axi_write(mcAddr(9, 5), 8'hE3, r);
    for (int n = 6; n <= 8; n++) axi_write(mcAddr(9, n), 8'hFF, r);
    eng_peek(4'h9);
    chk({31'h0, engIde}, 32'h0000_0000, "standard");
    chk({3'h0, engId}, {3'h0, 8'hFF, 3'b111, 18'h0}, "std id");
    axi_write(12'h200, 8'h09, r);
    axi_read(12'h200, d, r);
    chk(d, 32'h0000_0009, "select");
    axi_read(12'h208, d, r);
    chk(d, {3'h0, 8'hFF, 3'b111, 18'h0}, "decoded id");
    $display("test_standard done");
  endtask

  task automatic test_reset_keep();
    logic [31:0] d;
    logic [1:0] r;
    do_reset();
    axi_read(mcAddr(3, 6), d, r);
    chk(d, 32'h0000_0096, "kept byte");
    axi_read(12'h200, d, r);
    chk(d, 32'h0000_0000, "select reset");
    eng_peek(4'h3);
    chk({3'h0, engId}, EXT_ID3, "kept id");
    $display("test_reset_keep done");
  endtask

  task automatic test_errors();
    logic [31:0] d;
    logic [1:0] r;
    axi_read(12'h300, d, r);
    chk({30'h0, r}, 32'h0000_0002, "unmapped resp");
    chk(d, 32'h0000_0000, "unmapped data");
    axi_write(12'h204, 8'h55, r);
    chk({30'h0, r}, 32'h0000_0002, "ro write resp");
    // Byte lane 0 off: answered OKAY but the stored byte stays
    wstrb <= 4'h0;
    axi_write(mcAddr(3, 2), 8'hFF, r);
    wstrb <= 4'h1;
    chk({30'h0, r}, 32'h0000_0000, "no lane resp");
    axi_read(mcAddr(3, 2), d, r);
    chk(d, 32'h0000_005A, "no lane kept");
    $display("test_errors done");
  endtask

  initial
  begin
    errorCnt = 0;
    nTests = 0;
    resetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'h1;
    engMbSel = 4'h0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    test_init();
    test_layout();
    test_length();
    test_standard();
    test_reset_keep();
    test_errors();
    final_report();
  end
endmodule // testbench
